// File: scs_clock_select.sv
// system clock source selector with glitch-free switching
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ns
module scs_clock_select (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // configuration straps
    input wire logic [1:0] i_cfg_osc_select,
    input wire logic i_clock_output_enable_cfg_n,
    // timers that need the slow oscillator
    input wire logic i_powerup_timer_en,
    input wire logic i_watchdog_timer_en,
    // register port
    input wire logic [scs_pkg::ADDR_W-1:0] i_addr,
    input wire logic [scs_pkg::DATA_W-1:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [scs_pkg::DATA_W-1:0] o_rd_data,
    // clock input pin
    input wire logic i_clock_input_pin,
    output logic o_clock_input_released,
    // clock output pin and its io fallback
    input wire logic i_gpio_out,
    input wire logic i_gpio_oe,
    output logic o_clock_output_pin,
    output logic o_clock_output_oe,
    // system clock and status
    output logic o_sys_clk,
    output logic [1:0] o_active_src,
    output logic o_switch_busy,
    output logic o_timer_tick,
    output logic o_fast_osc_en,
    output logic o_slow_osc_en,
    output logic o_fast_osc_ready,
    output logic o_fast_osc_stable,
    output logic o_slow_osc_ready
);
    scs_osc_if fast_if ();
    scs_osc_if slow_if ();

    logic [1:0] cfg_q;
    logic clock_output_pin_cfg_n_q;
    logic [3:0] freq_q;
    logic [1:0] src_sel_q;
    logic [scs_pkg::DATA_W-1:0] rd_data_q;
    logic ext_meta_q;
    logic ext_sync_q;
    scs_pkg::scs_src_t act_src_q;
    logic [scs_pkg::SHIFT_W-1:0] act_shift_q;
    scs_pkg::scs_sw_state_t state_q;
    logic [scs_pkg::DIV_W-1:0] div_cnt_q;
    logic sys_q;
    logic clock_output_pin_q;
    logic clock_output_pin_oe_q;
    logic released_q;

    logic internal_sel;
    logic slow_pick;
    scs_pkg::scs_src_t tgt_src;
    logic [scs_pkg::SHIFT_W-1:0] tgt_shift;
    logic tgt_ready;
    logic need_switch;
    logic do_switch;
    logic [scs_pkg::DIV_W-1:0] div_last;

    // ========================================
    // prescaler decode: half period in fast ticks is 2**shift
    function automatic logic [scs_pkg::SHIFT_W-1:0] freq_shift(input logic [3:0] code);
        logic [scs_pkg::SHIFT_W-1:0] s;
        s = 4'h0;
        if (code[3])
        begin
            s = 4'hF - code;
        end
        else if (code[2])
        begin
            s = 4'hC - code;
        end
        else
        begin
            s = 4'h9;
        end
        return s;
    endfunction

    // ========================================
    // oscillators
    scs_osc_gen #(
        .START_CYC(scs_pkg::FAST_START_CYC),
        .STABLE_CYC(scs_pkg::FAST_STABLE_CYC),
        .HALF_CYC(scs_pkg::FAST_HALF_CYC)
    ) u_fast (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .osc(fast_if.gen)
    );

    scs_osc_gen #(
        .START_CYC(scs_pkg::SLOW_START_CYC),
        .STABLE_CYC(scs_pkg::SLOW_STABLE_CYC),
        .HALF_CYC(scs_pkg::SLOW_HALF_CYC)
    ) u_slow (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .osc(slow_if.gen)
    );

    // ========================================
    // source selection
    // reserved select code 01 behaves as 00
    assign internal_sel = src_sel_q[1] || (cfg_q == scs_pkg::CFG_INTERNAL);
    assign slow_pick = (freq_q[3:1] == scs_pkg::FREQ_SLOW_TOP);

    always_comb
    begin
        if (!internal_sel)
        begin
            tgt_src = scs_pkg::SRC_EXT;
        end
        else if (slow_pick)
        begin
            tgt_src = scs_pkg::SRC_SLOW;
        end
        else
        begin
            tgt_src = scs_pkg::SRC_FAST;
        end
    end

    assign tgt_shift = freq_shift(freq_q);

    // the old source stays enabled until the switch completes,
    // otherwise its clock could freeze high and hang the switch
    assign fast_if.en = (internal_sel && !slow_pick) || (act_src_q == scs_pkg::SRC_FAST);
    assign slow_if.en = (internal_sel && slow_pick) || (act_src_q == scs_pkg::SRC_SLOW)
        || i_powerup_timer_en || i_watchdog_timer_en;

    always_comb
    begin
        unique case (tgt_src)
            scs_pkg::SRC_FAST: tgt_ready = fast_if.ready;
            scs_pkg::SRC_SLOW: tgt_ready = slow_if.ready;
            default: tgt_ready = 1'b1;
        endcase
    end

    assign need_switch = (tgt_src != act_src_q)
        || ((tgt_src == scs_pkg::SRC_FAST) && (tgt_shift != act_shift_q));

    // switch only in a low phase; entering the external clock also
    // waits for its low phase so no short high pulse appears
    assign do_switch = (state_q == scs_pkg::SW_FALL) && need_switch && tgt_ready && !sys_q
        && !((tgt_src == scs_pkg::SRC_EXT) && ext_sync_q);

    // ========================================
    // configuration capture at reset
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            cfg_q <= i_cfg_osc_select;
            clock_output_pin_cfg_n_q <= i_clock_output_enable_cfg_n;
        end
    end

    // ========================================
    // control register
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            freq_q <= scs_pkg::FREQ_RST;
            src_sel_q <= scs_pkg::SRC_SEL_RST;
        end
        else if (i_wr && (i_addr == scs_pkg::ADDR_CTRL))
        begin
            freq_q <= i_wr_data[scs_pkg::FREQ_MSB:scs_pkg::FREQ_LSB];
            src_sel_q <= i_wr_data[scs_pkg::SRC_SEL_MSB:scs_pkg::SRC_SEL_LSB];
        end
    end

    // ========================================
    // register reads, data valid the cycle after the strobe
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst || !i_rd)
        begin
            rd_data_q <= '0;
        end
        else if (i_addr == scs_pkg::ADDR_CTRL)
        begin
            rd_data_q <= '0;
            rd_data_q[scs_pkg::FREQ_MSB:scs_pkg::FREQ_LSB] <= freq_q;
            rd_data_q[scs_pkg::SRC_SEL_MSB:scs_pkg::SRC_SEL_LSB] <= src_sel_q;
        end
        else if (i_addr == scs_pkg::ADDR_STAT)
        begin
            rd_data_q <= '0;
            rd_data_q[scs_pkg::STAT_FAST_READY] <= fast_if.ready;
            rd_data_q[scs_pkg::STAT_SLOW_READY] <= slow_if.ready;
            rd_data_q[scs_pkg::STAT_FAST_STABLE] <= fast_if.stable;
        end
        else
        begin
            rd_data_q <= '0;
        end
    end

    // ========================================
    // external clock synchroniser
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
        end
        else
        begin
            ext_meta_q <= i_clock_input_pin;
            ext_sync_q <= ext_meta_q;
        end
    end

    // ========================================
    // switch sequencer
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            state_q <= scs_pkg::SW_RUN;
            act_shift_q <= freq_shift(scs_pkg::FREQ_RST);
            // external mode is live at once, no start-up wait
            act_src_q <= (i_cfg_osc_select == scs_pkg::CFG_INTERNAL)
                ? scs_pkg::SRC_FAST : scs_pkg::SRC_EXT;
        end
        else
        begin
            unique case (state_q)
                scs_pkg::SW_RUN:
                begin
                    if (need_switch)
                    begin
                        // same oscillator is already ready: no start delay
                        state_q <= tgt_ready ? scs_pkg::SW_FALL : scs_pkg::SW_START;
                    end
                end
                scs_pkg::SW_START:
                begin
                    if (!need_switch)
                    begin
                        state_q <= scs_pkg::SW_RUN;
                    end
                    else if (tgt_ready)
                    begin
                        state_q <= scs_pkg::SW_FALL;
                    end
                end
                scs_pkg::SW_FALL:
                begin
                    if (!need_switch)
                    begin
                        state_q <= scs_pkg::SW_RUN;
                    end
                    else if (!tgt_ready)
                    begin
                        state_q <= scs_pkg::SW_START;
                    end
                    else if (do_switch)
                    begin
                        act_src_q <= tgt_src;
                        act_shift_q <= tgt_shift;
                        state_q <= scs_pkg::SW_RUN;
                    end
                end
                default:
                begin
                    state_q <= scs_pkg::SW_RUN;
                end
            endcase
        end
    end

    // ========================================
    // system clock generation
    assign div_last = scs_pkg::DIV_W'((1 << act_shift_q) - 1);

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst || do_switch)
        begin
            // new source starts low; only the fast divider restarts, so a full low phase is kept for the fast source alone
            sys_q <= 1'b0;
            div_cnt_q <= '0;
        end
        else
        begin
            unique case (act_src_q)
                scs_pkg::SRC_EXT:
                begin
                    // no edges means no state change: the device just waits
                    sys_q <= ext_sync_q;
                end
                scs_pkg::SRC_FAST:
                begin
                    if (fast_if.tick)
                    begin
                        if (div_cnt_q == div_last)
                        begin
                            sys_q <= !sys_q;
                            div_cnt_q <= '0;
                        end
                        else
                        begin
                            div_cnt_q <= div_cnt_q + 1'b1;
                        end
                    end
                end
                scs_pkg::SRC_SLOW:
                begin
                    if (slow_if.tick)
                    begin
                        sys_q <= !sys_q;
                    end
                end
                default:
                begin
                    sys_q <= sys_q;
                end
            endcase
        end
    end

    // ========================================
    // pins
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            clock_output_pin_q <= 1'b0;
            clock_output_pin_oe_q <= 1'b0;
            released_q <= 1'b0;
        end
        else
        begin
            clock_output_pin_q <= clock_output_pin_cfg_n_q ? i_gpio_out : sys_q;
            clock_output_pin_oe_q <= clock_output_pin_cfg_n_q ? i_gpio_oe : 1'b1;
            released_q <= (cfg_q == scs_pkg::CFG_INTERNAL);
        end
    end

    // ========================================
    // outputs
    assign o_rd_data = rd_data_q;
    assign o_clock_input_released = released_q;
    assign o_clock_output_pin = clock_output_pin_q;
    assign o_clock_output_oe = clock_output_pin_oe_q;
    assign o_sys_clk = sys_q;
    assign o_active_src = act_src_q;
    assign o_switch_busy = (state_q != scs_pkg::SW_RUN);
    assign o_timer_tick = slow_if.tick;
    assign o_fast_osc_en = fast_if.en;
    assign o_slow_osc_en = slow_if.en;
    assign o_fast_osc_ready = fast_if.ready;
    assign o_fast_osc_stable = fast_if.stable;
    assign o_slow_osc_ready = slow_if.ready;
endmodule

// File: scs_pkg.sv
// constants and types shared by the system clock selector
package scs_pkg;
    // ========================================
    // timing
    localparam int CORE_PERIOD_NS = 100;
    localparam int FAST_START_NS = 2000;
    localparam int FAST_START_CYC = (FAST_START_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int FAST_STABLE_NS = 5000;
    localparam int FAST_STABLE_CYC = (FAST_STABLE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int FAST_HALF_CYC = 1;
    localparam int SLOW_HALF_CYC = 16;
    localparam int SLOW_START_PERIODS = 2;
    localparam int SLOW_START_CYC = SLOW_START_PERIODS * 2 * SLOW_HALF_CYC;
    localparam int SLOW_STABLE_CYC = 1;
    // ========================================
    // register map
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h1;
    localparam int FREQ_LSB = 3;
    localparam int FREQ_MSB = 6;
    localparam int SRC_SEL_LSB = 0;
    localparam int SRC_SEL_MSB = 1;
    localparam int STAT_FAST_READY = 4;
    localparam int STAT_SLOW_READY = 1;
    localparam int STAT_FAST_STABLE = 0;
    localparam logic [3:0] FREQ_RST = 4'h7;
    localparam logic [1:0] SRC_SEL_RST = 2'h0;
    // ========================================
    // configuration oscillator field, slow-select frequency code and prescaler widths
    localparam logic [1:0] CFG_INTERNAL = 2'h0;
    localparam logic [1:0] CFG_EXT_LOW = 2'h1;
    localparam logic [1:0] CFG_EXT_MEDIUM = 2'h2;
    localparam logic [1:0] CFG_EXT_HIGH = 2'h3;
    localparam logic [2:0] FREQ_SLOW_TOP = 3'h0;
    localparam int SHIFT_W = 4;
    localparam int DIV_W = 10;
    // ========================================
    // types
    typedef enum logic [1:0] {SRC_EXT, SRC_FAST, SRC_SLOW} scs_src_t;
    typedef enum logic [1:0] {SW_RUN, SW_START, SW_FALL} scs_sw_state_t;
endpackage

// File: scs_osc_if.sv
// control and status of one internal oscillator
`timescale 1ns/1ns
interface scs_osc_if;
    logic en;
    logic ready;
    logic stable;
    logic tick;
    modport gen (input en, output ready, output stable, output tick);
    modport user (output en, input ready, input stable, input tick);
endinterface

// File: scs_osc_gen.sv
// internal oscillator model: start-up, settling and half-period ticks
`timescale 1ns/1ns
module scs_osc_gen #(
    parameter int START_CYC = 2,
    parameter int STABLE_CYC = 1,
    parameter int HALF_CYC = 1
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // oscillator port
    scs_osc_if.gen osc
);
    localparam int SW = $clog2(START_CYC + 1);
    localparam int TW = $clog2(STABLE_CYC + 1);
    localparam int HW = $clog2(HALF_CYC + 1);
    localparam logic [SW-1:0] START_LAST = SW'(START_CYC);
    localparam logic [TW-1:0] STABLE_LAST = TW'(STABLE_CYC);
    localparam logic [HW-1:0] HALF_LAST = HW'(HALF_CYC - 1);

    logic [SW-1:0] start_cnt_q;
    logic [TW-1:0] stable_cnt_q;
    logic [HW-1:0] half_cnt_q;
    logic ready_q;
    logic stable_q;
    logic tick_q;

    // ========================================
    // start-up and settling
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst || !osc.en)
        begin
            start_cnt_q <= '0;
            stable_cnt_q <= '0;
            ready_q <= 1'b0;
            stable_q <= 1'b0;
        end
        else if (!ready_q)
        begin
            start_cnt_q <= start_cnt_q + 1'b1;
            ready_q <= (start_cnt_q == START_LAST - 1'b1);
        end
        else if (!stable_q)
        begin
            stable_cnt_q <= stable_cnt_q + 1'b1;
            stable_q <= (stable_cnt_q == STABLE_LAST - 1'b1);
        end
    end

    // ========================================
    // ticks only once the oscillator runs
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst || !ready_q)
        begin
            half_cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= (half_cnt_q == HALF_LAST);
            half_cnt_q <= (half_cnt_q == HALF_LAST) ? '0 : half_cnt_q + 1'b1;
        end
    end

    assign osc.ready = ready_q;
    assign osc.stable = stable_q;
    assign osc.tick = tick_q;
endmodule

// File: scs_clock_select_checker.sv
// port-level assertions for the system clock selector
`timescale 1ns/1ns
module scs_clock_select_checker (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // inputs watched
    input wire logic i_clock_output_enable_cfg_n,
    input wire logic i_powerup_timer_en,
    input wire logic i_watchdog_timer_en,
    input wire logic i_clock_input_pin,
    input wire logic i_gpio_out,
    input wire logic i_gpio_oe,
    // outputs watched
    input wire logic o_clock_output_pin,
    input wire logic o_clock_output_oe,
    input wire logic o_sys_clk,
    input wire logic [1:0] o_active_src,
    input wire logic o_switch_busy,
    input wire logic o_fast_osc_en,
    input wire logic o_slow_osc_en,
    input wire logic o_fast_osc_ready,
    input wire logic o_fast_osc_stable,
    input wire logic o_slow_osc_ready
);
    // ========================================
    // io mode strap, captured the way the design samples it
    logic io_mode_q;
    always_ff @(posedge i_core_clk)
        if (i_rst)
            io_mode_q <= i_clock_output_enable_cfg_n;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    // ========================================
    // assertions
    a_io_passthru: assert property (io_mode_q |-> ##1 (o_clock_output_oe == $past(i_gpio_oe) &&
        o_clock_output_pin == $past(i_gpio_out))) else $error("io fallback not passed to clock output pin");
    // pipeline reset must be three cycles old before the pin can be traced
    a_ext_follow: assert property (o_active_src == 2'h0 && $past(o_active_src, 3) == 2'h0 && !o_switch_busy &&
        !$past(i_rst, 3) |-> o_sys_clk == $past(i_clock_input_pin, 3)) else $error("system clock not tracking pin");
    a_switch_low: assert property ($changed(o_active_src) |-> !o_sys_clk && $past(o_switch_busy))
        else $error("source changed outside a low phase");
    a_fast_clear: assert property (!o_fast_osc_en && !$past(o_fast_osc_en) && !$past(o_fast_osc_en, 2) |->
        !o_fast_osc_ready && !o_fast_osc_stable) else $error("fast status set while disabled");
    a_slow_clear: assert property (!o_slow_osc_en && !$past(o_slow_osc_en) && !$past(o_slow_osc_en, 2) |->
        !o_slow_osc_ready) else $error("slow ready set while disabled");
    a_stable_ready: assert property (o_fast_osc_stable |-> o_fast_osc_ready)
        else $error("stable without ready");
    a_fast_start: assert property ($rose(o_fast_osc_ready) |-> $past(o_fast_osc_en, 10))
        else $error("fast ready without start-up time");
    // a switch may only land on an oscillator that already runs
    a_src_fast: assert property ($changed(o_active_src) && o_active_src == 2'h1 |-> o_fast_osc_ready)
        else $error("fast source taken before it was ready");
    a_src_slow: assert property ($changed(o_active_src) && o_active_src == 2'h2 |-> o_slow_osc_ready)
        else $error("slow source taken before it was ready");
    a_timer_keep: assert property (i_powerup_timer_en || i_watchdog_timer_en |-> o_slow_osc_en)
        else $error("slow oscillator off with a timer on");
endmodule
bind scs_clock_select scs_clock_select_checker chk_u (.i_core_clk, .i_rst, .i_clock_output_enable_cfg_n,
    .i_powerup_timer_en, .i_watchdog_timer_en, .i_clock_input_pin, .i_gpio_out, .i_gpio_oe, .o_clock_output_pin,
    .o_clock_output_oe, .o_sys_clk, .o_active_src, .o_switch_busy, .o_fast_osc_en, .o_slow_osc_en,
    .o_fast_osc_ready, .o_fast_osc_stable, .o_slow_osc_ready);

// File: scs_ext_clk_src.sv
// behavioural external clock source on the clock input pin
`timescale 1ns/1ns
module scs_ext_clk_src #(
    parameter int HALF_NS = 400
) (
    // control from the bench
    input wire logic i_run,
    // clock input pin
    output logic o_pin
);
    // ========================================
    // free timer offset so pin edges never meet core clock edges
    initial
    begin
        o_pin = 1'b0;
        #13;
        forever
        begin
            #HALF_NS;
            o_pin = i_run ? ~o_pin : 1'b0;
        end
    end
endmodule

// File: tb_top.sv
// self-checking bench for the system clock selector
`timescale 1ns/1ns
module tb_top;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [1:0] i_cfg_osc_select = 2'h3;
    logic i_clock_output_enable_cfg_n = 1'b0;
    logic i_powerup_timer_en = 1'b0;
    logic i_watchdog_timer_en = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wr_data = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_gpio_out = 1'b0;
    logic i_gpio_oe = 1'b0;
    logic ext_run = 1'b0;
    logic i_clock_input_pin;
    logic [7:0] o_rd_data;
    logic [1:0] o_active_src;
    logic o_clock_input_released, o_clock_output_pin, o_clock_output_oe, o_sys_clk, o_switch_busy, o_timer_tick;
    logic o_fast_osc_en, o_slow_osc_en, o_fast_osc_ready, o_fast_osc_stable, o_slow_osc_ready;
    logic [3:0] codes [5] = '{4'hF, 4'hC, 4'h8, 4'h4, 4'h2};
    int halves [5] = '{1, 8, 128, 256, 512};
    int num_errors = 0;
    int total_checks = 0;
    int ticks;
    logic held;
    always #50 i_core_clk = ~i_core_clk;
    scs_clock_select dut_u (.i_core_clk, .i_rst, .i_cfg_osc_select, .i_clock_output_enable_cfg_n,
        .i_powerup_timer_en, .i_watchdog_timer_en, .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data,
        .i_clock_input_pin, .o_clock_input_released, .i_gpio_out, .i_gpio_oe, .o_clock_output_pin,
        .o_clock_output_oe, .o_sys_clk, .o_active_src, .o_switch_busy, .o_timer_tick, .o_fast_osc_en,
        .o_slow_osc_en, .o_fast_osc_ready, .o_fast_osc_stable, .o_slow_osc_ready);
    scs_ext_clk_src ext_u (.i_run(ext_run), .o_pin(i_clock_input_pin));
    // ========================================
    // tasks
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic timeout;
        num_errors++;
        $display("wrong value at %0t: wait ran out", $time);
        close_out();
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    task automatic do_reset(input logic [1:0] cfg, input logic io);
        i_cfg_osc_select <= cfg;
        i_clock_output_enable_cfg_n <= io;
        i_rst <= 1'b1;
        tick(20);
        i_rst <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wr_data <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        check(o_rd_data, exp);
    endtask
    // busy may rise a cycle late, so give it two edges first
    task automatic wait_idle(input int lim);
        int n = 0;
        tick(2);
        #1;
        while (o_switch_busy !== 1'b0 && n < lim)
        begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        if (n >= lim)
            timeout();
    endtask
    // first interval is partial, the second one is measured
    task automatic half(input int exp);
        int n = 0;
        logic v;
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            v = o_sys_clk;
            while (o_sys_clk === v && n < 2000)
            begin
                @(posedge i_core_clk);
                #1;
                n++;
            end
        end
        if (n >= 2000)
            timeout();
        check(n, exp);
    endtask
    // ========================================
    // main sequence
    initial
    begin
        do_reset(2'h3, 1'b0);
        ext_run <= 1'b1;
        rd(scs_pkg::ADDR_CTRL, 8'h38);
        rd(scs_pkg::ADDR_STAT, 8'h00);
        check(o_active_src, 2'h0);
        check(o_clock_input_released, 1'b0);
        check(o_clock_output_oe, 1'b1);
        check(o_fast_osc_en, 1'b0);
        half(4);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00);
        wr(scs_pkg::ADDR_STAT, 8'hFF);
        rd(scs_pkg::ADDR_STAT, 8'h00);
        rd(scs_pkg::ADDR_CTRL, 8'h38);
        wr(scs_pkg::ADDR_CTRL, 8'h3A);
        wait_idle(200);
        check(o_active_src, 2'h1);
        check(o_fast_osc_en, 1'b1);
        rd(scs_pkg::ADDR_STAT, 8'h10);
        tick(60);
        rd(scs_pkg::ADDR_STAT, 8'h11);
        half(32);
        foreach (codes[i])
        begin
            wr(scs_pkg::ADDR_CTRL, {1'b0, codes[i], 3'h2});
            wait_idle(600);
            half(halves[i]);
            check(o_fast_osc_stable, 1'b1);
        end
        wr(scs_pkg::ADDR_CTRL, 8'h02);
        #1;
        check(o_slow_osc_en, 1'b1);
        wait_idle(300);
        check(o_active_src, 2'h2);
        tick(3);
        rd(scs_pkg::ADDR_STAT, 8'h02);
        half(16);
        ticks = 0;
        repeat (40)
        begin
            @(posedge i_core_clk);
            #1;
            ticks += (o_timer_tick === 1'b1);
        end
        check(ticks > 0, 1'b1);
        wr(scs_pkg::ADDR_CTRL, 8'h38);
        wait_idle(300);
        check(o_active_src, 2'h0);
        tick(3);
        rd(scs_pkg::ADDR_STAT, 8'h00);
        tick(1);
        i_watchdog_timer_en <= 1'b1;
        tick(1);
        #1;
        check(o_slow_osc_en, 1'b1);
        tick(1);
        i_watchdog_timer_en <= 1'b0;
        i_powerup_timer_en <= 1'b1;
        tick(1);
        #1;
        check(o_slow_osc_en, 1'b1);
        tick(1);
        i_powerup_timer_en <= 1'b0;
        ext_run <= 1'b0;
        tick(10);
        #1;
        held = o_sys_clk;
        tick(30);
        #1;
        check(o_sys_clk, held);
        check(held, 1'b0);
        ext_run <= 1'b1;
        half(4);
        wr(scs_pkg::ADDR_CTRL, 8'h7B);
        for (int c = 1; c < 3; c++)
        begin
            do_reset(c[1:0], 1'b0);
            tick(1);
            #1;
            check(o_active_src, 2'h0);
            check(o_clock_input_released, 1'b0);
            tick(1);
        end
        do_reset(2'h0, 1'b1);
        i_gpio_out <= 1'b1;
        i_gpio_oe <= 1'b1;
        tick(2);
        #1;
        check(o_active_src, 2'h1);
        check(o_clock_input_released, 1'b1);
        check({o_clock_output_pin, o_clock_output_oe}, 2'h3);
        rd(scs_pkg::ADDR_CTRL, 8'h38);
        wr(scs_pkg::ADDR_CTRL, 8'h39);
        tick(5);
        #1;
        check(o_active_src, 2'h1);
        half(32);
        close_out();
    end
endmodule
